// *** isr_ctrl_model.sv ***
`timescale 1ns/100ps
// ----
// controller side of the command port
// ----
module isr_ctrl_model (
	input wire logic mclk,
	input wire logic readValid,
	input wire logic [15:0] readData,
	output logic [3:0] regSelect,
	output logic regRead,
	output logic regWrite,
	output logic [15:0] writeData
);
	initial
	begin
		regSelect = 4'h0;
		regRead = 1'b0;
		regWrite = 1'b0;
		writeData = 16'hA5A5;
	end
	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		@(posedge mclk);
		regSelect <= s;
		writeData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		// no stale data left on idle bus
		writeData <= ~d;
	endtask
	task automatic rd(input logic [3:0] s, output logic [15:0] d);
		@(posedge mclk);
		regSelect <= s;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		d = (readValid === 1'b1) ? readData : 16'hBAD0;
	endtask
endmodule

// *** isr_event_group.sv ***
`timescale 1ns/100ps
module isr_event_group #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] EVENT_RESET = '0
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] conditionIn,
	input wire logic clearRead,
	input wire logic maskWrite,
	input wire logic [WIDTH-1:0] maskData,
	output logic [WIDTH-1:0] condition,
	output logic [WIDTH-1:0] eventLatch,
	output logic [WIDTH-1:0] eventMask,
	output logic summary
);

	typedef struct packed {
		logic [WIDTH-1:0] condition;
		logic [WIDTH-1:0] eventLatch;
		logic [WIDTH-1:0] eventMask;
		logic summary;
	} isr_group_type;

	isr_group_type state;
	isr_group_type next_state;

	always_comb
	begin
		next_state = state;
		next_state.condition = conditionIn;
		next_state.eventLatch = (clearRead ? '0 : state.eventLatch) | conditionIn;
		if (maskWrite)
		begin
			next_state.eventMask = maskData;
		end
		// summary registered on the same edge as latch and mask
		next_state.summary = |(next_state.eventLatch & next_state.eventMask);
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state <= '{condition: '0, eventLatch: EVENT_RESET, eventMask: '0, summary: 1'b0};
		end
		else
		begin
			state <= next_state;
		end
	end

	assign condition = state.condition;
	assign eventLatch = state.eventLatch;
	assign eventMask = state.eventMask;
	assign summary = state.summary;

endmodule

// *** isr_pkg.sv ***
package isr_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int GROUP_WIDTH = 16;
	localparam int BYTE_WIDTH = 8;
	localparam int SELECT_WIDTH = 4;

	// ----------------------------------------
	// register selectors on the command port
	// ----------------------------------------
	localparam logic [3:0] SEL_OPER_COND = 4'h0;
	localparam logic [3:0] SEL_OPER_EVENT = 4'h1;
	localparam logic [3:0] SEL_OPER_MASK = 4'h2;
	localparam logic [3:0] SEL_QUES_COND = 4'h3;
	localparam logic [3:0] SEL_QUES_EVENT = 4'h4;
	localparam logic [3:0] SEL_QUES_MASK = 4'h5;
	localparam logic [3:0] SEL_STD_EVENT = 4'h6;
	localparam logic [3:0] SEL_STD_MASK = 4'h7;
	localparam logic [3:0] SEL_STATUS_BYTE = 4'h8;
	localparam logic [3:0] SEL_SRQ_MASK = 4'h9;

	// ----------------------------------------
	// operation group bits
	// ----------------------------------------
	localparam int OPER_CAL_BIT = 0;
	localparam int OPER_WAVEFORM_BIT = 3;
	localparam int OPER_ACQ_BIT = 4;

	// ----------------------------------------
	// questionable group bits
	// ----------------------------------------
	localparam int QUES_LEVEL_BIT = 0;
	localparam int QUES_OVERCURRENT_BIT = 1;
	localparam int QUES_OVERHEAT_BIT = 3;
	localparam int QUES_SHUTDOWN_BIT = 9;
	localparam int QUES_RMS_LIMIT_BIT = 12;

	// ----------------------------------------
	// standard event bits
	// ----------------------------------------
	localparam int STD_OPC_BIT = 0;
	localparam int STD_QUERY_ERR_BIT = 2;
	localparam int STD_DEVICE_ERR_BIT = 3;
	localparam int STD_EXEC_ERR_BIT = 4;
	localparam int STD_CMD_ERR_BIT = 5;
	localparam int STD_POWER_ON_BIT = 7;
	localparam logic [7:0] STD_EVENT_RESET = 8'h80;

	// ----------------------------------------
	// status byte bits
	// ----------------------------------------
	localparam int STB_QUES_BIT = 3;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MSS_BIT = 6;
	localparam int STB_OPER_BIT = 7;

	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage

// *** isr_status_asserts.sv ***
`timescale 1ns/100ps
module isr_status_asserts (
	input wire logic mclk,
	input wire logic reset,
	input wire logic queueNotEmpty,
	input wire logic [3:0] regSelect,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [15:0] writeData,
	input wire logic [15:0] readData,
	input wire logic readValid,
	input wire logic [7:0] statusByte,
	input wire logic masterSummary
);
	// ----
	// skip first edge after reset
	// ----
	logic resetDly;
	always_ff @(posedge mclk)
		resetDly <= reset;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset || resetDly);
	property p_answer; regRead |=> readValid; endproperty
	property p_quiet; !regRead |=> !readValid; endproperty
	property p_hold; !regRead |=> $stable(readData); endproperty
	property p_mask;
		regWrite && !regRead && regSelect == isr_pkg::SEL_OPER_MASK ##1 !regWrite ##1
		regRead && regSelect == isr_pkg::SEL_OPER_MASK |=> readData == $past(writeData, 3);
	endproperty
	property p_spare; regRead && regSelect == isr_pkg::SEL_QUES_COND |=> !readData[14]; endproperty
	property p_narrow; regRead && regSelect >= isr_pkg::SEL_STD_EVENT |=> readData[15:8] == 8'h00; endproperty
	property p_unused; statusByte[2:0] == 3'h0; endproperty
	property p_master; masterSummary == statusByte[6]; endproperty
	property p_queue; queueNotEmpty[*3] |-> statusByte[4]; endproperty
	a_answer: assert property (p_answer) else $error("read not answered");
	a_quiet: assert property (p_quiet) else $error("spurious read valid");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_mask: assert property (p_mask) else $error("mask readback wrong");
	a_spare: assert property (p_spare) else $error("spare bit set");
	a_narrow: assert property (p_narrow) else $error("byte read not zero extended");
	a_unused: assert property (p_unused) else $error("unused status bits set");
	a_master: assert property (p_master) else $error("master summary mismatch");
	a_queue: assert property (p_queue) else $error("message bit missing");
	c_event: cover property (regRead && regSelect == isr_pkg::SEL_QUES_EVENT);
	c_master: cover property (masterSummary);
	c_oper: cover property (statusByte[7]);
endmodule
bind isr_status_top isr_status_asserts u_asserts (.mclk, .reset, .queueNotEmpty, .regSelect, .regRead,
	.regWrite, .writeData, .readData, .readValid, .statusByte, .masterSummary);

// *** isr_status_byte.sv ***
`timescale 1ns/100ps
module isr_status_byte (
	input wire logic mclk,
	input wire logic reset,
	input wire logic operSummary,
	input wire logic quesSummary,
	input wire logic standardSummary,
	input wire logic queueNotEmpty,
	input wire logic maskWrite,
	input wire logic [7:0] maskData,
	output logic [7:0] statusByte,
	output logic [7:0] serviceMask,
	output logic masterSummary
);

	typedef struct packed {
		logic [7:0] statusByte;
		logic [7:0] serviceMask;
		logic masterSummary;
	} isr_stb_type;

	isr_stb_type state;
	isr_stb_type next_state;
	logic [7:0] summaryBits;

	always_comb
	begin
		next_state = state;
		summaryBits = isr_pkg::ZERO_BYTE;
		summaryBits[isr_pkg::STB_OPER_BIT] = operSummary;
		summaryBits[isr_pkg::STB_QUES_BIT] = quesSummary;
		summaryBits[isr_pkg::STB_ESB_BIT] = standardSummary;
		summaryBits[isr_pkg::STB_MAV_BIT] = queueNotEmpty;
		if (maskWrite)
		begin
			next_state.serviceMask = maskData;
		end
		next_state.masterSummary = |(summaryBits & next_state.serviceMask);
		next_state.statusByte = summaryBits;
		next_state.statusByte[isr_pkg::STB_MSS_BIT] = next_state.masterSummary;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state <= '{statusByte: isr_pkg::ZERO_BYTE, serviceMask: isr_pkg::ZERO_BYTE, masterSummary: 1'b0};
		end
		else
		begin
			state <= next_state;
		end
	end

	assign statusByte = state.statusByte;
	assign serviceMask = state.serviceMask;
	assign masterSummary = state.masterSummary;

endmodule

// *** isr_status_top.sv ***
`timescale 1ns/100ps
// How it works
// - condition registers mirror live circuits, read-only
// - event registers latch, clear on read except bits whose condition is still set
// - enable masks select events into summary
// - enabled operation events form status bit 7
// - enabled questionable events form status bit 3
// - operation bits: calibration, waveform, acquisition done
// - questionable bits: level fault, overcurrent, overheat
// - questionable: shutdown bit 9, rms 12, 14 unused
// - standard events: completion and four error kinds
// - standard event register read-only, clears on read
// - controller programs standard mask; device applies it
// - power-on sets standard bit 7
// - status byte: MAV 4, ESB 5, MSS 6
// - power-on clears all groups and masks, except standard event bit 7
// - master summary is masked OR, registered one cycle after group summaries
// - MAV set while output queue not empty
module isr_status_top (
	input wire logic mclk,
	input wire logic reset,
	input wire logic calibrationDone,
	input wire logic waveformSequenceDone,
	input wire logic acquisitionDone,
	input wire logic outputLevelFault,
	input wire logic overcurrentTrip,
	input wire logic overheatFlag,
	input wire logic remoteShutdown,
	input wire logic rmsCurrentLimit,
	input wire logic operationComplete,
	input wire logic queryError,
	input wire logic deviceError,
	input wire logic executionError,
	input wire logic commandError,
	input wire logic queueNotEmpty,
	input wire logic [3:0] regSelect,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [15:0] writeData,
	output logic [15:0] readData,
	output logic readValid,
	output logic [7:0] statusByte,
	output logic masterSummary
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] readData;
		logic readValid;
	} isr_top_type;

	isr_top_type state;
	isr_top_type next_state;

	logic [15:0] operCondIn;
	logic [15:0] quesCondIn;
	logic [7:0] stdCondIn;
	logic [15:0] operCond;
	logic [15:0] operEvent;
	logic [15:0] operMask;
	logic [15:0] quesCond;
	logic [15:0] quesEvent;
	logic [15:0] quesMask;
	logic [7:0] stdEvent;
	logic [7:0] stdMask;
	logic [7:0] serviceMask;
	logic operSummary;
	logic quesSummary;
	logic stdSummary;
	logic isRead;
	logic isWrite;

	// ----------------------------------------
	// condition wiring
	// ----------------------------------------
	always_comb
	begin
		operCondIn = isr_pkg::ZERO_WORD;
		operCondIn[isr_pkg::OPER_CAL_BIT] = calibrationDone;
		operCondIn[isr_pkg::OPER_WAVEFORM_BIT] = waveformSequenceDone;
		operCondIn[isr_pkg::OPER_ACQ_BIT] = acquisitionDone;
		quesCondIn = isr_pkg::ZERO_WORD;
		quesCondIn[isr_pkg::QUES_LEVEL_BIT] = outputLevelFault;
		quesCondIn[isr_pkg::QUES_OVERCURRENT_BIT] = overcurrentTrip;
		quesCondIn[isr_pkg::QUES_OVERHEAT_BIT] = overheatFlag;
		// shutdown and rms limit; bit 14 stays zero
		quesCondIn[isr_pkg::QUES_SHUTDOWN_BIT] = remoteShutdown;
		quesCondIn[isr_pkg::QUES_RMS_LIMIT_BIT] = rmsCurrentLimit;
		stdCondIn = isr_pkg::ZERO_BYTE;
		stdCondIn[isr_pkg::STD_OPC_BIT] = operationComplete;
		stdCondIn[isr_pkg::STD_QUERY_ERR_BIT] = queryError;
		stdCondIn[isr_pkg::STD_DEVICE_ERR_BIT] = deviceError;
		stdCondIn[isr_pkg::STD_EXEC_ERR_BIT] = executionError;
		stdCondIn[isr_pkg::STD_CMD_ERR_BIT] = commandError;
	end

	// read wins if both strobes arrive together
	assign isRead = regRead;
	assign isWrite = regWrite & ~regRead;

	// ----------------------------------------
	// groups
	// ----------------------------------------
	isr_event_group #(.WIDTH(isr_pkg::GROUP_WIDTH), .EVENT_RESET(isr_pkg::ZERO_WORD)) operGroup (
		.mclk(mclk),
		.reset(reset),
		.conditionIn(operCondIn),
		.clearRead(isRead && regSelect == isr_pkg::SEL_OPER_EVENT),
		.maskWrite(isWrite && regSelect == isr_pkg::SEL_OPER_MASK),
		.maskData(writeData),
		.condition(operCond),
		.eventLatch(operEvent),
		.eventMask(operMask),
		.summary(operSummary)
	);

	isr_event_group #(.WIDTH(isr_pkg::GROUP_WIDTH), .EVENT_RESET(isr_pkg::ZERO_WORD)) quesGroup (
		.mclk(mclk),
		.reset(reset),
		.conditionIn(quesCondIn),
		.clearRead(isRead && regSelect == isr_pkg::SEL_QUES_EVENT),
		.maskWrite(isWrite && regSelect == isr_pkg::SEL_QUES_MASK),
		.maskData(writeData),
		.condition(quesCond),
		.eventLatch(quesEvent),
		.eventMask(quesMask),
		.summary(quesSummary)
	);

	// power-on bit set out of reset
	isr_event_group #(.WIDTH(isr_pkg::BYTE_WIDTH), .EVENT_RESET(isr_pkg::STD_EVENT_RESET)) stdGroup (
		.mclk(mclk),
		.reset(reset),
		.conditionIn(stdCondIn),
		.clearRead(isRead && regSelect == isr_pkg::SEL_STD_EVENT),
		.maskWrite(isWrite && regSelect == isr_pkg::SEL_STD_MASK),
		.maskData(writeData[7:0]),
		.condition(),
		.eventLatch(stdEvent),
		.eventMask(stdMask),
		.summary(stdSummary)
	);

	isr_status_byte statusUnit (
		.mclk(mclk),
		.reset(reset),
		.operSummary(operSummary),
		.quesSummary(quesSummary),
		.standardSummary(stdSummary),
		.queueNotEmpty(queueNotEmpty),
		.maskWrite(isWrite && regSelect == isr_pkg::SEL_SRQ_MASK),
		.maskData(writeData[7:0]),
		.statusByte(statusByte),
		.serviceMask(serviceMask),
		.masterSummary(masterSummary)
	);

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb
	begin
		next_state.readValid = isRead;
		next_state.readData = state.readData;
		if (isRead)
		begin
			unique case (regSelect)
				isr_pkg::SEL_OPER_COND: next_state.readData = operCond;
				isr_pkg::SEL_OPER_EVENT: next_state.readData = operEvent;
				isr_pkg::SEL_OPER_MASK: next_state.readData = operMask;
				isr_pkg::SEL_QUES_COND: next_state.readData = quesCond;
				isr_pkg::SEL_QUES_EVENT: next_state.readData = quesEvent;
				isr_pkg::SEL_QUES_MASK: next_state.readData = quesMask;
				isr_pkg::SEL_STD_EVENT: next_state.readData = {isr_pkg::ZERO_BYTE, stdEvent};
				isr_pkg::SEL_STD_MASK: next_state.readData = {isr_pkg::ZERO_BYTE, stdMask};
				isr_pkg::SEL_STATUS_BYTE: next_state.readData = {isr_pkg::ZERO_BYTE, statusByte};
				isr_pkg::SEL_SRQ_MASK: next_state.readData = {isr_pkg::ZERO_BYTE, serviceMask};
				// unmapped selectors read zero
				default: next_state.readData = isr_pkg::ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state <= '{readData: isr_pkg::ZERO_WORD, readValid: 1'b0};
		end
		else
		begin
			state <= next_state;
		end
	end

	assign readData = state.readData;
	assign readValid = state.readValid;

endmodule

// *** test_instrument_status_reporting.sv ***
`timescale 1ns/100ps
module test_instrument_status_reporting;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] oper = 3'h0;
	logic [4:0] ques = 5'h00;
	logic [4:0] stdEv = 5'h00;
	logic queueNotEmpty = 1'b0;
	logic [3:0] regSelect;
	logic regRead, regWrite, readValid, masterSummary;
	logic [15:0] writeData, readData, got;
	logic [7:0] statusByte;
	int badCount = 0;
	int checkCount = 0;
	int cycles = 0;
	always #5 mclk = ~mclk;
	isr_status_top u_dut (.mclk, .reset, .calibrationDone(oper[0]), .waveformSequenceDone(oper[1]),
		.acquisitionDone(oper[2]), .outputLevelFault(ques[0]), .overcurrentTrip(ques[1]), .overheatFlag(ques[2]),
		.remoteShutdown(ques[3]), .rmsCurrentLimit(ques[4]), .operationComplete(stdEv[0]), .queryError(stdEv[1]),
		.deviceError(stdEv[2]), .executionError(stdEv[3]), .commandError(stdEv[4]), .queueNotEmpty, .regSelect,
		.regRead, .regWrite, .writeData, .readData, .readValid, .statusByte, .masterSummary);
	isr_ctrl_model u_ctrl (.mclk, .readValid, .readData, .regSelect, .regRead, .regWrite, .writeData);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checkCount++;
		if (g !== e)
		begin
			badCount++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rdChk(input logic [3:0] s, input logic [15:0] e);
		u_ctrl.rd(s, got);
		chk(got, e);
	endtask
	// summaries need a few edges to settle
	task automatic sbChk(input logic [7:0] e);
		repeat (3) @(posedge mclk);
		#1;
		chk({8'h00, statusByte}, {8'h00, e});
		chk({15'h0000, masterSummary}, {15'h0000, e[6]}); // master output
	endtask
	task automatic finalReport;
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			badCount++;
			finalReport;
		end
	end
	initial
	begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		rdChk(isr_pkg::SEL_STD_MASK, 16'h0000); // masks clear
		u_ctrl.wr(isr_pkg::SEL_STD_MASK, 16'h0080); // enable power-on
		sbChk(8'h20); // masked summary
		rdChk(isr_pkg::SEL_STD_EVENT, 16'h0080); // power-on bit
		rdChk(isr_pkg::SEL_STD_EVENT, 16'h0000); // cleared
		@(posedge mclk) oper <= 3'h7;
		rdChk(isr_pkg::SEL_OPER_COND, 16'h0019); // bit map
		u_ctrl.wr(isr_pkg::SEL_OPER_EVENT, 16'hFFFF); // write ignored
		@(posedge mclk) oper <= 3'h0;
		rdChk(isr_pkg::SEL_OPER_COND, 16'h0000); // live mirror
		rdChk(isr_pkg::SEL_OPER_EVENT, 16'h0019); // latched
		rdChk(isr_pkg::SEL_OPER_EVENT, 16'h0000); // cleared
		u_ctrl.wr(isr_pkg::SEL_OPER_MASK, 16'h0008); // mask write
		rdChk(isr_pkg::SEL_OPER_MASK, 16'h0008); // readback
		@(posedge mclk) oper <= 3'h1;
		@(posedge mclk) oper <= 3'h0;
		sbChk(8'h00); // masked out
		@(posedge mclk) oper <= 3'h2;
		@(posedge mclk) oper <= 3'h0;
		sbChk(8'h80); // operation summary
		rdChk(isr_pkg::SEL_OPER_EVENT, 16'h0009); // both latched
		sbChk(8'h00); // summary drops
		@(posedge mclk) ques <= 5'h1F;
		rdChk(isr_pkg::SEL_QUES_COND, 16'h120B); // bit map
		u_ctrl.wr(isr_pkg::SEL_QUES_COND, 16'h0000); // write refused
		rdChk(isr_pkg::SEL_QUES_COND, 16'h120B); // still live
		u_ctrl.wr(isr_pkg::SEL_QUES_MASK, 16'h000B); // mask write
		rdChk(isr_pkg::SEL_QUES_MASK, 16'h000B); // readback
		sbChk(8'h08); // questionable summary
		u_ctrl.wr(isr_pkg::SEL_SRQ_MASK, 16'h0008); // service mask
		sbChk(8'h48); // master summary
		@(posedge mclk) ques <= 5'h01;
		rdChk(isr_pkg::SEL_QUES_EVENT, 16'h120B); // latched
		rdChk(isr_pkg::SEL_QUES_EVENT, 16'h0001); // not lost
		@(posedge mclk) ques <= 5'h00;
		sbChk(8'h48); // still latched
		rdChk(isr_pkg::SEL_QUES_EVENT, 16'h0001); // last event
		rdChk(isr_pkg::SEL_QUES_EVENT, 16'h0000); // cleared
		sbChk(8'h00); // drops
		@(posedge mclk) stdEv <= 5'h1F;
		@(posedge mclk) stdEv <= 5'h00;
		sbChk(8'h00); // masked out
		u_ctrl.wr(isr_pkg::SEL_STD_MASK, 16'h003D); // mask write
		sbChk(8'h20); // event summary
		rdChk(isr_pkg::SEL_STD_EVENT, 16'h003D); // bit map
		@(posedge mclk) queueNotEmpty <= 1'b1;
		sbChk(8'h10); // message bit
		u_ctrl.wr(isr_pkg::SEL_SRQ_MASK, 16'h0010); // service mask
		rdChk(isr_pkg::SEL_SRQ_MASK, 16'h0010); // mask readback
		sbChk(8'h50); // master summary
		rdChk(isr_pkg::SEL_STATUS_BYTE, 16'h0050); // status read
		@(posedge mclk) queueNotEmpty <= 1'b0;
		sbChk(8'h00); // queue empty
		rdChk(4'hF, 16'h0000); // unmapped reads zero
		@(posedge mclk) reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		rdChk(isr_pkg::SEL_SRQ_MASK, 16'h0000); // masks clear
		rdChk(isr_pkg::SEL_STD_EVENT, 16'h0080); // power-on again
		finalReport;
	end
endmodule
